// ---- hw/zmoc_ctrl.sv ----
// zero-setting, mastering and operator menu control with axi4-lite registers
`timescale 1ns/10ps
`default_nettype none
`include "zmoc_regs.svh"

// Contract
// - enter held 3 s opens menu; presses step
// - yellow led blinks in menu, steady otherwise
// - show menu number; top menu is 0000
// - working options used; declined save not stored
// - no save prompt when nothing changed
// - six fixed programs, four user slots, recallable
// - last saved user program active at power-on
// - menu 1900 clears users after 1910 confirmation
// - escape hold zeroes reading, shows relative
// - second hold clears offsets, needs valid reading
// - offsets reach display and analog, not digital
// - multi-segment program refuses zero and master
// - stored master: hold makes display show master
// - one master value per measurement program
// - low pulse 0.5-3 s zeroes or masters
// - low pulse 3-6 s clears temporary offsets
// - pulses under 0.5 s or over 6 s ignored
// - output settles gradually by averaging depth
// - trigger ignored while light control enabled
module zmoc_ctrl import zmoc_pkg::*; #(
   parameter int TICK_CYC = `ZM_TICK_NS / `ZM_CLK_NS  // cycles per ms
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // keypad and external inputs
   input  wire logic        enter_key,
   input  wire logic        escape_key,
   input  wire logic        ext_zero_n,
   input  wire logic        trig_in,
   // measurement path
   input  wire logic        meas_valid,
   input  wire logic [31:0] meas_value,
   // nonvolatile store, power-on contents
   input  wire logic        boot_user_ok,
   input  wire logic [3:0]  boot_user_prog,
   input  wire logic [15:0] boot_opt,
   // axi4-lite write address and data
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [11:0] s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // operator outputs
   output logic             led_yellow_q,
   output logic             relative_q,
   output logic [15:0]      menu_num_q,
   output logic [31:0]      display_q,
   output logic [31:0]      analog_q,
   output logic [31:0]      digital_q,
   output logic             trig_evt_q,
   // nonvolatile save request
   output logic             nv_save_q,
   output logic             nv_clear_q,
   output logic [3:0]       nv_prog_q,
   output logic [15:0]      nv_opt_q
);

   // ==========================================================
   // helpers
   // saturating ms counter step
   function automatic logic [12:0] ms_step(input logic [12:0] c);
      ms_step = (c == `ZM_SAT_MS) ? c : c + 13'd1;
   endfunction

   // byte-enable merge of a write into a word
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
      for (int i = 0; i < 4; i++) begin
         wmerge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   // ==========================================================
   // millisecond tick
   logic [$clog2(TICK_CYC)-1:0] div_q;   // clock divider
   logic                        tick_q;  // one-cycle ms pulse

   // divider producing the ms enable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == ($clog2(TICK_CYC))'(TICK_CYC - 1));
         div_q  <= (div_q == ($clog2(TICK_CYC))'(TICK_CYC - 1)) ?
                   '0 : div_q + 1'b1;
      end
   end

   // ==========================================================
   // key and pulse timers
   logic [12:0] ent_ms_q;   // enter held time
   logic [12:0] esc_ms_q;   // escape held time
   logic [12:0] ext_ms_q;   // external low time
   logic        ent_q;      // enter previous level
   logic        esc_q;      // escape previous level
   logic        ext_q;      // external previous level (active)
   logic        ent_done_q; // long enter already used
   logic        esc_done_q; // long escape already used

   wire ext_act   = !ext_zero_n;                      // pulled to ground
   wire ent_long  = tick_q && enter_key && !ent_done_q &&
                    (ms_step(ent_ms_q) == `ZM_HOLD_MS);
   wire esc_long  = tick_q && escape_key && !esc_done_q &&
                    (ms_step(esc_ms_q) == `ZM_HOLD_MS);
   wire ent_short = ent_q && !enter_key && !ent_done_q;
   wire esc_short = esc_q && !escape_key && !esc_done_q;
   wire ext_end   = ext_q && !ext_act;
   // classify the finished external pulse
   wire ext_zero  = ext_end && ext_ms_q >= `ZM_SHORT_MIN_MS &&
                    ext_ms_q < `ZM_LONG_MIN_MS;
   wire ext_clear = ext_end && ext_ms_q >= `ZM_LONG_MIN_MS &&
                    ext_ms_q <= `ZM_LONG_MAX_MS;

   // hold counters, cleared on release
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ent_ms_q   <= '0;
         esc_ms_q   <= '0;
         ext_ms_q   <= '0;
         ent_q      <= 1'b0;
         esc_q      <= 1'b0;
         ext_q      <= 1'b0;
         ent_done_q <= 1'b0;
         esc_done_q <= 1'b0;
      end else begin
         ent_q <= enter_key;
         esc_q <= escape_key;
         ext_q <= ext_act;
         // counts advance on the ms tick only
         if (!enter_key) ent_ms_q <= '0;
         else if (tick_q) ent_ms_q <= ms_step(ent_ms_q);
         if (!escape_key) esc_ms_q <= '0;
         else if (tick_q) esc_ms_q <= ms_step(esc_ms_q);
         if (!ext_act) ext_ms_q <= '0;
         else if (tick_q) ext_ms_q <= ms_step(ext_ms_q);
         // a long hold fires once, release rearms
         if (!enter_key) ent_done_q <= 1'b0;
         else if (ent_long) ent_done_q <= 1'b1;
         if (!escape_key) esc_done_q <= 1'b0;
         else if (esc_long) esc_done_q <= 1'b1;
      end
   end

   // ==========================================================
   // register storage
   zmoc_state_t  st_q;          // operator state
   logic         light_en_q;    // external light control enabled
   logic [2:0]   avg_shift_q;   // settling shift from averaging
   logic [3:0]   prog_q;        // active program
   logic [15:0]  opt_q;         // working option word
   logic         dirty_q;       // something changed in the menu
   logic [3:0]   user_used_q;   // occupied user slots
   logic         save_full_q;   // last save found no free slot
   logic [31:0]  master_q [10]; // master value per program
   logic [31:0]  offset_q;      // temporary offset
   logic         boot_q;        // power-on load pending
   logic [12:0]  blink_ms_q;    // blink timer

   // axi handshake state
   logic         aw_hold_q;
   logic         w_hold_q;
   logic [11:0]  awaddr_q;
   logic [31:0]  wdata_q;
   logic [3:0]   wstrb_q;

   // write decode
   wire         wr_go   = aw_hold_q && w_hold_q && !s_axi_bvalid;
   wire         wr_ctrl = wr_go && awaddr_q == `ZM_CTRL_OFS;
   wire         wr_prog = wr_go && awaddr_q == `ZM_PROG_OFS;
   wire         wr_opt  = wr_go && awaddr_q == `ZM_OPT_OFS;
   wire         wr_mast = wr_go && awaddr_q >= `ZM_MAST_BASE &&
                          awaddr_q <= `ZM_MAST_LAST && awaddr_q[1:0] == 2'h0;
   wire [3:0]   mast_wi = 4'((awaddr_q - `ZM_MAST_BASE) >> 2);
   wire         wr_hit  = wr_ctrl || wr_prog || wr_opt || wr_mast;
   wire         in_menu = st_q != ZMOC_MEAS;
   wire [31:0]  wr_val  = wmerge(32'h0, wdata_q, wstrb_q);
   // program and option edits only in the menu
   wire         prog_ok = wr_prog && in_menu &&
                          wr_val[3:0] <= `ZM_PROG_LAST &&
                          (wr_val[3:0] < `ZM_PROG_USER0 ||
                           user_used_q[2'(wr_val[3:0] - `ZM_PROG_USER0)]);
   wire         opt_ok  = wr_opt && in_menu;
   wire         mast_ok = wr_mast && in_menu;

   // ==========================================================
   // zero and master requests
   wire       mseg     = prog_q == `ZM_PROG_MSEG;
   wire       key_tog  = st_q == ZMOC_MEAS && esc_long && meas_valid;
   wire       ext_ok   = st_q == ZMOC_MEAS && meas_valid;
   wire       do_set   = !mseg && ((key_tog && !relative_q) ||
                         (ext_zero && ext_ok));
   wire       do_clr   = !mseg && ((key_tog && relative_q) ||
                         (ext_clear && ext_ok));
   wire [31:0] mast_v  = master_q[prog_q];
   // zero when master is zero, else reading becomes the master
   wire [31:0] new_off = meas_value - mast_v;
   wire [31:0] target  = meas_value - offset_q;

   // save slot: overwrite active user slot, else first free one
   wire       act_user = prog_q >= `ZM_PROG_USER0;
   wire [1:0] act_slot = 2'(prog_q - `ZM_PROG_USER0);
   wire [1:0] free_slot = !user_used_q[0] ? 2'd0 : !user_used_q[1] ? 2'd1 :
                          !user_used_q[2] ? 2'd2 : 2'd3;
   wire       have_slot = act_user || !(&user_used_q);
   wire [1:0] save_slot = act_user ? act_slot : free_slot;

   // ==========================================================
   // operator state machine
   zmoc_state_t st_d;
   logic [15:0] menu_d;

   // next state from key events
   always_comb begin
      st_d   = st_q;
      menu_d = menu_num_q;
      case (st_q)
         ZMOC_MEAS: begin
            if (ent_long) begin
               st_d   = ZMOC_MENU;
               menu_d = `ZM_MENU_TOP;
            end
         end
         ZMOC_MENU: begin
            if (ent_short && menu_num_q == `ZM_MENU_CLR) begin
               st_d   = ZMOC_CONF;
               menu_d = `ZM_MENU_CONF;
            end else if (ent_short) begin
               menu_d = (menu_num_q + `ZM_MENU_STEP == `ZM_MENU_WRAP) ?
                        `ZM_MENU_TOP : menu_num_q + `ZM_MENU_STEP;
            end else if (esc_short) begin
               st_d = dirty_q ? ZMOC_SAVE : ZMOC_MEAS;
            end
         end
         ZMOC_SAVE: begin
            if (ent_short || esc_short) begin
               st_d = ZMOC_MEAS;
            end
         end
         ZMOC_CONF: begin
            if (ent_short || esc_short) begin
               st_d   = ZMOC_MENU;
               menu_d = `ZM_MENU_CLR;
            end
         end
         default: begin
            st_d   = ZMOC_MEAS;
            menu_d = `ZM_MENU_TOP;
         end
      endcase
   end

   wire save_now  = st_q == ZMOC_SAVE && ent_short && have_slot;
   wire clear_now = st_q == ZMOC_CONF && ent_short;

   // state, menu number and led
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q         <= ZMOC_MEAS;
         menu_num_q   <= `ZM_MENU_TOP;
         blink_ms_q   <= '0;
         led_yellow_q <= 1'b1;
      end else begin
         st_q       <= st_d;
         menu_num_q <= menu_d;
         // blink in the menu, steady while measuring
         if (st_d == ZMOC_MEAS) begin
            led_yellow_q <= 1'b1;
            blink_ms_q   <= '0;
         end else if (tick_q && blink_ms_q == `ZM_BLINK_MS) begin
            led_yellow_q <= !led_yellow_q;
            blink_ms_q   <= '0;
         end else if (tick_q) begin
            blink_ms_q <= blink_ms_q + 13'd1;
         end
      end
   end

   // ==========================================================
   // settings, programs and offsets
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         light_en_q  <= 1'b0;
         avg_shift_q <= '0;
         prog_q      <= '0;
         opt_q       <= `ZM_OPT_RST;
         dirty_q     <= 1'b0;
         user_used_q <= '0;
         save_full_q <= 1'b0;
         offset_q    <= '0;
         relative_q  <= 1'b0;
         boot_q      <= 1'b1;
         nv_save_q   <= 1'b0;
         nv_clear_q  <= 1'b0;
         nv_prog_q   <= '0;
         nv_opt_q    <= `ZM_OPT_RST;
         for (int i = 0; i < 10; i++) master_q[i] <= '0;
      end else begin
         nv_save_q  <= 1'b0;
         nv_clear_q <= 1'b0;
         boot_q     <= 1'b0;
         // power-on: last saved user program and options
         if (boot_q) begin
            opt_q <= boot_opt;
            if (boot_user_ok) begin
               prog_q <= boot_user_prog;
               user_used_q[2'(boot_user_prog - `ZM_PROG_USER0)] <= 1'b1;
            end
         end
         if (wr_ctrl) begin
            light_en_q  <= wr_val[`ZM_CTRL_LIGHT];
            avg_shift_q <= wr_val[3:1];
         end
         if (prog_ok) prog_q <= wr_val[3:0];
         if (opt_ok) opt_q <= wr_val[15:0];
         if (mast_ok) master_q[mast_wi] <= wmerge(master_q[mast_wi],
                                          wdata_q, wstrb_q);
         if (prog_ok || opt_ok || mast_ok) dirty_q <= 1'b1;
         // a program written to the program register drops any temporary offset
         if (do_set) begin
            offset_q   <= new_off;
            relative_q <= 1'b1;
         end else if (do_clr || prog_ok) begin
            offset_q   <= '0;
            relative_q <= 1'b0;
         end
         if (st_q == ZMOC_SAVE && (ent_short || esc_short)) begin
            // an edit landing in the same cycle keeps the flag set
            dirty_q     <= prog_ok || opt_ok || mast_ok;
            save_full_q <= !have_slot;
         end
         // store program and options only on accepted save
         if (save_now) begin
            user_used_q[save_slot] <= 1'b1;
            prog_q    <= `ZM_PROG_USER0 + 4'(save_slot);
            nv_save_q <= 1'b1;
            nv_prog_q <= `ZM_PROG_USER0 + 4'(save_slot);
            nv_opt_q  <= opt_q;
         end
         // confirmed erase of users and options
         if (clear_now) begin
            user_used_q <= '0;
            opt_q       <= `ZM_OPT_RST;
            nv_opt_q    <= `ZM_OPT_RST;
            nv_clear_q  <= 1'b1;
            if (act_user) prog_q <= '0;
         end
      end
   end

   // ==========================================================
   // output paths
   wire [31:0] step = $signed(target - display_q) >>> avg_shift_q;

   // display converges, analog follows it outside the multi-segment program, digital stays raw
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         display_q  <= '0;
         analog_q   <= '0;
         digital_q  <= '0;
         trig_evt_q <= 1'b0;
      end else begin
         digital_q  <= meas_value;
         trig_evt_q <= trig_in && !light_en_q;
         if (tick_q) begin
            display_q <= (step == 32'h0) ? target : display_q + step;
            analog_q  <= mseg ? 32'h0 :
                         ((step == 32'h0) ? target : display_q + step);
         end
      end
   end

   // ==========================================================
   // axi4-lite slave, one write and one read at a time
   logic [31:0] rd_val;
   wire  [11:0] ra = s_axi_araddr;
   wire  ra_mast = ra >= `ZM_MAST_BASE && ra <= `ZM_MAST_LAST &&
                   ra[1:0] == 2'h0;
   wire  [3:0] mast_ri = 4'((ra - `ZM_MAST_BASE) >> 2);

   // read data mux
   always_comb begin
      rd_val = 32'h0;
      case (ra)
         `ZM_CTRL_OFS: rd_val = {28'h0, avg_shift_q, light_en_q};
         `ZM_PROG_OFS: rd_val = {28'h0, prog_q};
         `ZM_OPT_OFS:  rd_val = {16'h0, opt_q};
         `ZM_STAT_OFS: rd_val = {menu_num_q, 3'h0, save_full_q,
                                 user_used_q, st_q, 2'h0,
                                 dirty_q, relative_q};
         `ZM_OFFS_OFS: rd_val = offset_q;
         default:      rd_val = ra_mast ? master_q[mast_ri] : 32'h0;
      endcase
   end
   wire ra_hit = ra <= `ZM_OFFS_OFS && ra[1:0] == 2'h0 || ra_mast;

   // channel handshakes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         awaddr_q      <= '0;
         wdata_q       <= '0;
         wstrb_q       <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `ZM_RESP_OK;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `ZM_RESP_OK;
      end else begin
         s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         // response once both halves are in
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `ZM_RESP_OK : `ZM_RESP_DEC;
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // read: accept, answer next cycle
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= ra_hit ? `ZM_RESP_OK : `ZM_RESP_DEC;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ---- hw/zmoc_regs.svh ----
// register offsets, field positions and timing constants of the zero/master block
`ifndef ZMOC_REGS_SVH
`define ZMOC_REGS_SVH
// ==========================================================
// timing
`define ZM_CLK_NS        100
`define ZM_TICK_NS       1000000
`define ZM_HOLD_MS       13'd3000
`define ZM_SHORT_MIN_MS  13'd500
`define ZM_LONG_MIN_MS   13'd3000
`define ZM_LONG_MAX_MS   13'd6000
`define ZM_SAT_MS        13'd6001
`define ZM_BLINK_MS      13'd250
// ==========================================================
// register byte offsets
`define ZM_CTRL_OFS      12'h000
`define ZM_PROG_OFS      12'h004
`define ZM_OPT_OFS       12'h008
`define ZM_STAT_OFS      12'h00C
`define ZM_OFFS_OFS      12'h010
`define ZM_MAST_BASE     12'h040
`define ZM_MAST_LAST     12'h064
// ==========================================================
// fields and codes
`define ZM_CTRL_LIGHT    0
`define ZM_PROG_MSEG     4'h4
`define ZM_PROG_USER0    4'h6
`define ZM_PROG_LAST     4'h9
`define ZM_MENU_TOP      16'h0000
`define ZM_MENU_STEP     16'h0064
`define ZM_MENU_CLR      16'h076C
`define ZM_MENU_CONF     16'h0776
`define ZM_MENU_WRAP     16'h07D0
`define ZM_OPT_RST       16'h0000
`define ZM_RESP_OK       2'h0
`define ZM_RESP_DEC      2'h3
`endif

// ---- hw/zmoc_pkg.sv ----
// types shared by the zero/master control block
package zmoc_pkg;
   // ==========================================================
   // operator state, one-hot
   typedef enum logic [3:0] {
      ZMOC_MEAS = 4'h1,   // measuring
      ZMOC_MENU = 4'h2,   // setup menu
      ZMOC_SAVE = 4'h4,   // save prompt on leaving
      ZMOC_CONF = 4'h8    // clear-user-data confirmation
   } zmoc_state_t;
endpackage

// ---- tb/zmoc_ctrl_assertions.sv ----
// checker for the zero/master control block ports
`timescale 1ns/10ps
`default_nettype none
module zmoc_ctrl_assertions (
   // clock, reset and watched inputs
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        trig_in,
   input wire logic        meas_valid,
   input wire logic [31:0] meas_value,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_rready,
   // watched outputs
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        relative_q,
   input wire logic [15:0] menu_num_q,
   input wire logic [31:0] digital_q,
   input wire logic        trig_evt_q,
   input wire logic        nv_clear_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // bus answers stand until taken; address ready is a one-cycle pulse
   sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
   sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
   bresp_hold_a: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   rdata_hold_a: assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("address ready longer than one cycle");
   // ==========================================================
   // operator paths
   digital_raw_a: assert property ($past(rst_n) |-> digital_q == $past(meas_value))
      else $error("digital value not raw reading");
   trig_gate_a: assert property ($past(rst_n) && trig_evt_q |-> $past(trig_in))
      else $error("trigger event without trigger");
   clear_conf_a: assert property (nv_clear_q |-> $past(menu_num_q) == 16'h0776 ##1 !nv_clear_q)
      else $error("erase without confirmation");
   menu_num_a: assert property ($changed(menu_num_q) |-> menu_num_q % 16'h0064 == 16'h0000 || menu_num_q == 16'h0776)
      else $error("menu number off grid");
   rel_valid_a: assert property ($rose(relative_q) |-> $past(meas_valid))
      else $error("offset taken without valid reading");
endmodule
`default_nettype wire

// ---- tb/zmoc_keypad.sv ----
// keypad and grounding switch model for the operator inputs
`timescale 1ns/10ps
`default_nettype none
module zmoc_keypad #(
   parameter int TCK = 2   // clock cycles per ms tick
) (
   // clock and operator lines
   input  wire logic ref_clk,
   output logic      enter_key,
   output logic      escape_key,
   output logic      ext_zero_n
);
   // idle: keys up, switch line pulled high
   initial begin
      {enter_key, escape_key, ext_zero_n} = 3'h1;
   end
   // hold a line for ms ticks: 0 enter, 1 escape, 2 switch
   task automatic act(input int k, input int ms);
      @(posedge ref_clk);
      {enter_key, escape_key, ext_zero_n} <= {k == 0, k == 1, k != 2};
      repeat (ms * TCK) @(posedge ref_clk);
      {enter_key, escape_key, ext_zero_n} <= 3'h1;
      repeat (20) @(negedge ref_clk);
   endtask
endmodule
`default_nettype wire

// ---- tb/zmoc_ctrl_tb_top.sv ----
// self-checking bench for the zero/master control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, sn) begin comparisons++; if ((sn) !== (ex)) begin \
   failures++; $display("mismatch %s expected %0h seen %0h", nm, ex, sn); \
   end end
module zmoc_ctrl_tb_top;
   localparam int TCK = 2;   // short ms tick for simulation
   logic        ref_clk, rst_n, trig_in, enter_key, escape_key, ext_zero_n;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, led_yellow_q, relative_q;
   logic        trig_evt_q, nv_save_q, nv_clear_q, seen;
   logic        meas_valid = 1'b1;
   logic        boot_user_ok = 1'b0;
   logic [3:0]  boot_user_prog = 4'h0;
   logic [15:0] boot_opt = 16'h0000;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [3:0]  nv_prog_q;
   logic [4:0]  hs;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [15:0] menu_num_q, nv_opt_q;
   logic [31:0] meas_value, s_axi_wdata, s_axi_rdata, display_q, analog_q;
   logic [31:0] digital_q, rd_data;
   int          failures, comparisons, clears;
   zmoc_ctrl #(.TICK_CYC(TCK)) dut (.*);
   zmoc_keypad #(.TCK(TCK)) kp (.*);
   always @(posedge ref_clk) clears += nv_clear_q;
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // one bus cycle, each channel released at its own handshake
   task automatic xfer(input bit wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
      {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
      do begin
         @(negedge ref_clk);
         hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
               s_axi_arvalid & s_axi_arready, s_axi_bvalid & s_axi_bready,
               s_axi_rvalid & s_axi_rready};
         if (hs[1:0] != 2'h0) begin
            rd_resp = wr ? s_axi_bresp : s_axi_rresp;
            rd_data = s_axi_rdata;
         end
         @(posedge ref_clk);
         {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready}
            <= {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} & ~hs;
      end while (s_axi_bready || s_axi_rready);
   endtask
   task automatic t_regs();
      `CHK("led", 1'b1, led_yellow_q)
      xfer(0, 12'h020, 32'h0);
      `CHK("decode", 34'h300000000, {rd_resp, rd_data})
      trig_in <= 1'b1;
      repeat (3) @(negedge ref_clk);
      `CHK("trig", 1'b1, trig_evt_q)
      xfer(1, 12'h000, 32'h00000001);
      repeat (3) @(negedge ref_clk);
      `CHK("trig gated", 1'b0, trig_evt_q)
      xfer(1, 12'h000, 32'h00000000);
      $display("test regs done");
   endtask
   task automatic t_zero();
      meas_value <= 32'h00001234;   // master left at zero so the hold zero-sets
      kp.act(1, 3100);
      `CHK("zeroed", 65'h100000000, {relative_q, display_q})
      `CHK("digital", 32'h00001234, digital_q)
      xfer(0, 12'h010, 32'h0);
      `CHK("offset", 32'h00001234, rd_data)
      kp.act(1, 3100);
      `CHK("absolute", 65'h000001234, {relative_q, analog_q})
      $display("test zero done");
   endtask
   task automatic t_ext();
      kp.act(2, 1000);
      `CHK("short pulse", 1'b1, relative_q)
      kp.act(2, 7000);
      `CHK("overlong", 1'b1, relative_q)
      kp.act(2, 4000);
      `CHK("long pulse", 1'b0, relative_q)
      kp.act(2, 100);
      `CHK("too short", 1'b0, relative_q)
      @(posedge ref_clk) meas_valid <= 1'b0;
      kp.act(2, 1000);
      `CHK("no reading", 1'b0, relative_q)
      @(posedge ref_clk) meas_valid <= 1'b1;
      $display("test ext done");
   endtask
   task automatic t_menu();
      kp.act(0, 3100);
      seen = 1'b1;
      repeat (520) @(negedge ref_clk) seen &= led_yellow_q;
      `CHK("blink", 1'b0, seen)
      kp.act(0, 50);
      `CHK("step", 16'h0064, menu_num_q)
      kp.act(1, 50);
      xfer(0, 12'h00C, 32'h0);
      `CHK("no prompt", 4'h1, rd_data[7:4])
      kp.act(0, 3100);
      repeat (20) kp.act(0, 50);
      `CHK("confirm", 16'h0776, menu_num_q)
      kp.act(0, 50);
      `CHK("erase", 1, clears)
      $display("test menu done");
   endtask
   task automatic t_master();
      xfer(1, 12'h040, 32'h00000100);
      kp.act(1, 50);
      xfer(0, 12'h00C, 32'h0);
      `CHK("save prompt", 4'h4, rd_data[7:4])
      kp.act(1, 50);
      kp.act(1, 3100);
      `CHK("mastered", 33'h100000100, {relative_q, display_q})
      `CHK("digital raw", 32'h00001234, digital_q)
      $display("test master done");
   endtask
   task automatic stop_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      {rst_n, trig_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
      {s_axi_arvalid, s_axi_rready, meas_value} = 34'h0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge ref_clk);
      t_regs();
      t_zero();
      t_ext();
      t_menu();
      t_master();
      stop_test();
   end
   initial begin
      #10000000;
      failures++;
      stop_test();
   end
endmodule
bind zmoc_ctrl zmoc_ctrl_assertions chk (.*);
`default_nettype wire
